// ### hw/spag_guard.sv
// How it works
// - Store instruction programs flash only when fetched from the boot section.
// - Boot code may target any page, boot pages too, subject to protection.
// - Boot size fuses set the app/boot boundary; every address in one section.
// - Fixed split into concurrent and stall regions; boot lies in stall region.
// - Concurrent region programming keeps the CPU running.
// - Stall region programming halts the CPU until the operation completes.
// - Busy flag reads one while the concurrent region is blocked.
// - Lock bits set by software or programmer; cleared only by chip erase or reset.
// - General write lock never blocks store-instruction programming.
// - General read/write lock never limits the CPU's own reads or stores.
// - App field: 11 free, 10 no write, 00 no write/read, 01 no read.
// - App field 00/01 with boot vectors suppresses interrupts in app code.
// - Boot field: 11 free, 10 no write, 00 no write/read, 01 no read.
// - Boot field 00/01 with app vectors suppresses interrupts in boot code.
// - The two protection fields are stored and programmed separately.
// - Busy set on concurrent erase/write; cleared by re-enable or page load.
// - Lock-set plus store enable, then store within four cycles, sets locks from R0.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
module spag_guard
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] boot_size_fuses,
    input wire logic vectors_in_boot,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire spag_pkg::spag_store_t store_req,
    input wire logic [14:0] fetch_pc,
    input wire logic [14:0] table_read_addr,
    input wire logic table_read_req,
    output logic table_read_allow,
    input wire logic flash_done,
    input wire logic prog_lock_write,
    input wire logic [7:0] prog_lock_data,
    input wire logic chip_erase,
    output spag_pkg::spag_flash_cmd_t flash_cmd,
    output logic cpu_stall,
    output logic irq_suppress,
    output logic concurrent_region_busy_flag,
    output logic [7:0] lock_bits
);
    import spag_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] lock_reg;
    logic [4:0] ctrl_reg;
    logic [2:0] arm_cnt_reg;
    logic busy_reg;
    logic stall_reg;
    logic op_active_reg;
    logic allow_reg;
    logic irq_sup_reg;
    logic [7:0] rdata_reg;
    spag_flash_cmd_t cmd_reg;

    logic [1:0] app_protection_field;
    logic [1:0] boot_protection_field;
    logic pc_boot, pc_stall_unused;
    logic tgt_boot, tgt_stall;
    logic fetch_boot, fetch_stall_unused;
    logic rd_boot, rd_stall_unused;
    logic armed;
    spag_cmd_t cmd_sel;
    logic write_blocked;
    logic prog_ok;
    logic lock_ok;
    logic reenable_ok;
    logic load_ok;
    logic read_blocked;

    ////////////////////////////////////////////////////////////////////////
    // Section classification of store pc, store target, fetch, table read
    spag_section_map u_map_pc
    (
        .boot_size_fuses(boot_size_fuses),
        .addr(store_req.pc),
        .in_boot(pc_boot),
        .in_stall(pc_stall_unused)
    );

    spag_section_map u_map_tgt
    (
        .boot_size_fuses(boot_size_fuses),
        .addr(store_req.target),
        .in_boot(tgt_boot),
        .in_stall(tgt_stall)
    );

    spag_section_map u_map_fetch
    (
        .boot_size_fuses(boot_size_fuses),
        .addr(fetch_pc),
        .in_boot(fetch_boot),
        .in_stall(fetch_stall_unused)
    );

    spag_section_map u_map_rd
    (
        .boot_size_fuses(boot_size_fuses),
        .addr(table_read_addr),
        .in_boot(rd_boot),
        .in_stall(rd_stall_unused)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decoding

    // Separate two-bit fields in the lock byte
    assign app_protection_field = lock_reg[SPAG_APP_LO_POS +: 2];
    assign boot_protection_field = lock_reg[SPAG_BOOT_LO_POS +: 2];

    assign armed = ctrl_reg[SPAG_BIT_STORE_EN] && (arm_cnt_reg != 3'h0);

    // Command chosen by the armed control bits
    always_comb
    begin
        if (ctrl_reg[SPAG_BIT_REENABLE])
            cmd_sel = SPAG_CMD_REENABLE;
        else if (ctrl_reg[SPAG_BIT_LOCK_SET])
            cmd_sel = SPAG_CMD_LOCK;
        else if (ctrl_reg[SPAG_BIT_WRITE])
            cmd_sel = SPAG_CMD_WRITE;
        else if (ctrl_reg[SPAG_BIT_ERASE])
            cmd_sel = SPAG_CMD_ERASE;
        else
            cmd_sel = SPAG_CMD_LOAD;
    end

    // Write gate from protection fields only, general lock ignored
    always_comb
    begin
        if (tgt_boot)
            write_blocked = (boot_protection_field == SPAG_PROT_NO_WRITE)
                || (boot_protection_field == SPAG_PROT_NO_RW);
        else
            write_blocked = (app_protection_field == SPAG_PROT_NO_WRITE)
                || (app_protection_field == SPAG_PROT_NO_RW);
    end

    // Only boot-fetched store instructions act
    assign prog_ok = store_req.valid && armed && pc_boot && !op_active_reg
        && ((cmd_sel == SPAG_CMD_ERASE) || (cmd_sel == SPAG_CMD_WRITE))
        && !write_blocked;
    assign lock_ok = store_req.valid && armed && pc_boot
        && (cmd_sel == SPAG_CMD_LOCK);
    assign reenable_ok = store_req.valid && armed && pc_boot && !op_active_reg
        && (cmd_sel == SPAG_CMD_REENABLE);
    assign load_ok = store_req.valid && armed && pc_boot
        && (cmd_sel == SPAG_CMD_LOAD);

    // Cross-section table reads gated by the target section's field
    always_comb
    begin
        if (rd_boot && !fetch_boot)
            read_blocked = (boot_protection_field == SPAG_PROT_NO_RW)
                || (boot_protection_field == SPAG_PROT_NO_READ);
        else if (!rd_boot && fetch_boot)
            read_blocked = (app_protection_field == SPAG_PROT_NO_RW)
                || (app_protection_field == SPAG_PROT_NO_READ);
        else
            read_blocked = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register write and command window
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= 5'h00;
            arm_cnt_reg <= 3'h0;
        end
        else if (reg_write && reg_addr == SPAG_OFF_CTRL && !op_active_reg)
        begin
            // Only the documented bit combinations take effect
            case (reg_wdata[4:0])
                5'b10001, 5'b01001, 5'b00101, 5'b00011, 5'b00001:
                begin
                    ctrl_reg <= reg_wdata[4:0];
                    arm_cnt_reg <= SPAG_ARM_CYCLES;
                end
                default:
                begin
                    ctrl_reg <= ctrl_reg;
                    arm_cnt_reg <= arm_cnt_reg;
                end
            endcase
        end
        else if (op_active_reg && flash_done)
        begin
            ctrl_reg <= 5'h00;
            arm_cnt_reg <= 3'h0;
        end
        else if (store_req.valid && armed)
        begin
            // Erase/write keeps store enable high until done
            if (!prog_ok)
                ctrl_reg <= 5'h00;
            arm_cnt_reg <= 3'h0;
        end
        else if (arm_cnt_reg != 3'h0)
        begin
            arm_cnt_reg <= arm_cnt_reg - 3'h1;
            if (arm_cnt_reg == 3'h1 && !op_active_reg)
                ctrl_reg <= 5'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock bit storage
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            lock_reg <= SPAG_LOCK_RESET;
        else if (chip_erase)
            lock_reg <= SPAG_LOCK_ERASED;
        else if (prog_lock_write)
            lock_reg <= lock_reg & prog_lock_data;
        else if (lock_ok)
            lock_reg <= lock_reg & store_req.r0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Operation tracking and CPU stall
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            op_active_reg <= 1'b0;
            stall_reg <= 1'b0;
        end
        else if (prog_ok)
        begin
            op_active_reg <= 1'b1;
            stall_reg <= tgt_stall;
        end
        else if (op_active_reg && flash_done)
        begin
            op_active_reg <= 1'b0;
            stall_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Concurrent region busy flag
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            busy_reg <= 1'b0;
        else if (prog_ok && !tgt_stall)
            busy_reg <= 1'b1;
        else if (reenable_ok || load_ok)
            busy_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Command to the flash sequencer
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            cmd_reg <= '0;
        else
        begin
            cmd_reg.valid <= prog_ok || lock_ok || reenable_ok || load_ok;
            cmd_reg.cmd <= cmd_sel;
            cmd_reg.target <= store_req.target;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Table read permission and interrupt suppression
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            allow_reg <= 1'b0;
            irq_sup_reg <= 1'b0;
        end
        else
        begin
            allow_reg <= table_read_req && !read_blocked
                && !(busy_reg && !rd_stall_unused);
            if (vectors_in_boot)
                irq_sup_reg <= !fetch_boot && !app_protection_field[1];
            else
                irq_sup_reg <= fetch_boot && !boot_protection_field[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            rdata_reg <= 8'h00;
        else if (reg_read)
        begin
            case (reg_addr)
                SPAG_OFF_CTRL: rdata_reg <= {1'b0, busy_reg, 1'b0, ctrl_reg};
                SPAG_OFF_LOCK: rdata_reg <= lock_reg;
                SPAG_OFF_STAT: rdata_reg <= {5'h00, irq_sup_reg, stall_reg,
                    op_active_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end
        else
            rdata_reg <= 8'h00;
    end

    assign reg_rdata = rdata_reg;
    assign flash_cmd = cmd_reg;
    assign cpu_stall = stall_reg;
    assign irq_suppress = irq_sup_reg;
    assign concurrent_region_busy_flag = busy_reg;
    assign lock_bits = lock_reg;
    assign table_read_allow = allow_reg;

endmodule

// ### hw/spag_pkg.sv
package spag_pkg;

    // Flash geometry (word addresses)
    localparam int SPAG_ADDR_W = 15;
    localparam int SPAG_PAGE_W = 6;
    localparam int SPAG_DATA_W = 8;
    localparam logic [14:0] SPAG_STALL_REGION_START = 15'h3800;

    // Boot section start per boot size fuse setting (00 largest .. 11 smallest)
    localparam logic [14:0] SPAG_BOOT_START_00 = 15'h3800;
    localparam logic [14:0] SPAG_BOOT_START_01 = 15'h3c00;
    localparam logic [14:0] SPAG_BOOT_START_10 = 15'h3e00;
    localparam logic [14:0] SPAG_BOOT_START_11 = 15'h3f00;

    // Protection field codes, 1 means unprogrammed
    localparam logic [1:0] SPAG_PROT_NONE = 2'h3;
    localparam logic [1:0] SPAG_PROT_NO_WRITE = 2'h2;
    localparam logic [1:0] SPAG_PROT_NO_RW = 2'h0;
    localparam logic [1:0] SPAG_PROT_NO_READ = 2'h1;

    // Lock bit storage reset value and chip-erase value
    localparam logic [7:0] SPAG_LOCK_RESET = 8'hff;
    localparam logic [7:0] SPAG_LOCK_ERASED = 8'hff;
    localparam int SPAG_APP_LO_POS = 2;
    localparam int SPAG_BOOT_LO_POS = 4;

    // Control command window after the store enable bit is written
    localparam logic [2:0] SPAG_ARM_CYCLES = 3'h4;

    // Register offsets on the plain register port
    localparam logic [3:0] SPAG_OFF_CTRL = 4'h0;
    localparam logic [3:0] SPAG_OFF_LOCK = 4'h1;
    localparam logic [3:0] SPAG_OFF_STAT = 4'h2;

    // Control register bit positions
    localparam int SPAG_BIT_STORE_EN = 0;
    localparam int SPAG_BIT_ERASE = 1;
    localparam int SPAG_BIT_WRITE = 2;
    localparam int SPAG_BIT_LOCK_SET = 3;
    localparam int SPAG_BIT_REENABLE = 4;
    localparam int SPAG_BIT_BUSY = 6;

    // Programming command chosen by the armed control bits
    typedef enum logic [2:0] {
        SPAG_CMD_LOAD = 3'b000,
        SPAG_CMD_ERASE = 3'b001,
        SPAG_CMD_WRITE = 3'b010,
        SPAG_CMD_LOCK = 3'b011,
        SPAG_CMD_REENABLE = 3'b100
    } spag_cmd_t;

    // Store instruction request from the core
    typedef struct packed {
        logic valid;
        logic [14:0] pc;
        logic [14:0] target;
        logic [7:0] r0;
    } spag_store_t;

    // Command to the flash sequencer
    typedef struct packed {
        logic valid;
        spag_cmd_t cmd;
        logic [14:0] target;
    } spag_flash_cmd_t;

endpackage

// ### hw/spag_section_map.sv
// Classifies one address into boot/app and stall/concurrent regions
module spag_section_map
(
    input wire logic [1:0] boot_size_fuses,
    input wire logic [14:0] addr,
    output logic in_boot,
    output logic in_stall
);
    import spag_pkg::*;

    logic [14:0] boot_start;

    // Boundary from the fuse setting
    always_comb
    begin
        case (boot_size_fuses)
            2'b00: boot_start = SPAG_BOOT_START_00;
            2'b01: boot_start = SPAG_BOOT_START_01;
            2'b10: boot_start = SPAG_BOOT_START_10;
            default: boot_start = SPAG_BOOT_START_11;
        endcase
    end

    // Each address is in exactly one section
    assign in_boot = (addr >= boot_start);
    // Fixed split, boot starts never below it
    assign in_stall = (addr >= SPAG_STALL_REGION_START);

endmodule

// ### tb/spag_flash_model.sv
module spag_flash_model
    import spag_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire spag_flash_cmd_t flash_cmd,
    input wire logic slow,
    output logic flash_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] count_reg;

    // Busy countdown per command, short or long
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            count_reg <= 7'h00;
            flash_done <= 1'b0;
        end
        else
        begin
            flash_done <= (count_reg == 7'h01);
            if (flash_cmd.valid)
                count_reg <= slow ? 7'h28 : 7'h03;
            else if (count_reg != 7'h00)
                count_reg <= count_reg - 7'h01;
        end
    end
endmodule

// ### tb/spag_guard_sva.sv
module spag_guard_sva
    import spag_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] boot_size_fuses,
    input wire logic vectors_in_boot,
    input wire spag_store_t store_req,
    input wire logic [14:0] fetch_pc,
    input wire logic [14:0] table_read_addr,
    input wire logic table_read_req,
    input wire logic table_read_allow,
    input wire logic flash_done,
    input wire logic chip_erase,
    input wire spag_flash_cmd_t flash_cmd,
    input wire logic cpu_stall,
    input wire logic irq_suppress,
    input wire logic concurrent_region_busy_flag,
    input wire logic [7:0] lock_bits
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [14:0] bs;
    logic wr_cmd;

    // Boot start from fuses, erase or write issued
    assign bs = boot_size_fuses == 2'h0 ? SPAG_BOOT_START_00 :
        boot_size_fuses == 2'h1 ? SPAG_BOOT_START_01 :
        boot_size_fuses == 2'h2 ? SPAG_BOOT_START_10 : SPAG_BOOT_START_11;
    assign wr_cmd = flash_cmd.valid &&
        (flash_cmd.cmd == SPAG_CMD_ERASE || flash_cmd.cmd == SPAG_CMD_WRITE);

    property p_app_pc;
        store_req.valid && store_req.pc < bs |=> !flash_cmd.valid;
    endproperty
    a_app_pc: assert property (p_app_pc) else $error("app store started a command");
    property p_cmd_cause;
        flash_cmd.valid |-> $past(store_req.valid);
    endproperty
    a_cmd_cause: assert property (p_cmd_cause) else $error("command without store");
    property p_stall;
        wr_cmd && flash_cmd.target >= SPAG_STALL_REGION_START |-> cpu_stall;
    endproperty
    a_stall: assert property (p_stall) else $error("stall region op not stalled");
    property p_rww;
        wr_cmd && flash_cmd.target < SPAG_STALL_REGION_START
            |-> concurrent_region_busy_flag && !cpu_stall;
    endproperty
    a_rww: assert property (p_rww) else $error("concurrent op wrong busy or stall");
    property p_stall_hold;
        cpu_stall && !flash_done |=> cpu_stall;
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("stall dropped early");
    property p_busy_cause;
        $rose(concurrent_region_busy_flag) |-> $past(store_req.valid);
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy set without store");
    property p_lock_prog;
        !$past(chip_erase) |-> (lock_bits & ~$past(lock_bits)) == 8'h00;
    endproperty
    a_lock_prog: assert property (p_lock_prog) else $error("lock bit unprogrammed");
    property p_lock_erase;
        chip_erase |=> lock_bits == 8'hff;
    endproperty
    a_lock_erase: assert property (p_lock_erase) else $error("chip erase kept locks");
    property p_wr_prot;
        store_req.valid && ((store_req.target < bs && !lock_bits[SPAG_APP_LO_POS]) ||
            (store_req.target >= bs && !lock_bits[SPAG_BOOT_LO_POS])) |=> !wr_cmd;
    endproperty
    a_wr_prot: assert property (p_wr_prot) else $error("protected write issued");
    property p_rd_prot;
        table_read_req && fetch_pc >= bs && table_read_addr < bs && !lock_bits[3]
            |=> !table_read_allow;
    endproperty
    a_rd_prot: assert property (p_rd_prot) else $error("protected read allowed");
    property p_irq_app;
        (vectors_in_boot && !lock_bits[3] && fetch_pc < bs) [*2] |-> irq_suppress;
    endproperty
    a_irq_app: assert property (p_irq_app) else $error("irq not suppressed in app");
    property p_irq_boot;
        (!vectors_in_boot && !lock_bits[5] && fetch_pc >= bs) [*2] |-> irq_suppress;
    endproperty
    a_irq_boot: assert property (p_irq_boot) else $error("irq not suppressed in boot");

    c_stall: cover property (wr_cmd && cpu_stall);
    c_busy_clear: cover property ($fell(concurrent_region_busy_flag));
    c_lock: cover property ($fell(lock_bits[3]));
endmodule

bind spag_guard spag_guard_sva u_sva (.clock(clock), .rst_n(rst_n),
    .boot_size_fuses(boot_size_fuses), .vectors_in_boot(vectors_in_boot),
    .store_req(store_req), .fetch_pc(fetch_pc), .table_read_addr(table_read_addr),
    .table_read_req(table_read_req), .table_read_allow(table_read_allow),
    .flash_done(flash_done), .chip_erase(chip_erase), .flash_cmd(flash_cmd),
    .cpu_stall(cpu_stall), .irq_suppress(irq_suppress),
    .concurrent_region_busy_flag(concurrent_region_busy_flag), .lock_bits(lock_bits));

// ### tb/testbench.sv
module testbench;
    import spag_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst_n, vib, reg_write, reg_read, tr_req, tr_allow, done, cerase, slow;
    logic stall, irq, busy;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, rdata, lock, d;
    logic [14:0] fetch_pc, tr_addr;
    spag_store_t store_req;
    spag_flash_cmd_t fcmd;
    int failures, samples_checked, cycles;

    spag_guard uut (.clock(clock), .rst_n(rst_n), .boot_size_fuses(2'h3),
        .vectors_in_boot(vib), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
        .store_req(store_req), .fetch_pc(fetch_pc), .table_read_addr(tr_addr),
        .table_read_req(tr_req), .table_read_allow(tr_allow), .flash_done(done),
        .prog_lock_write(1'b0), .prog_lock_data(8'hff), .chip_erase(cerase),
        .flash_cmd(fcmd), .cpu_stall(stall), .irq_suppress(irq),
        .concurrent_region_busy_flag(busy), .lock_bits(lock));
    spag_flash_model u_flash (.clock(clock), .rst_n(rst_n), .flash_cmd(fcmd),
        .slow(slow), .flash_done(done));

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task final_report;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Control write, then store in the arm window
    task store(input logic [7:0] ctl, input logic [14:0] pc, input logic [14:0] tgt,
        input logic [7:0] r0);
        @(posedge clock);
        reg_addr <= SPAG_OFF_CTRL;
        reg_wdata <= ctl;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        store_req <= '{valid: 1'b1, pc: pc, target: tgt, r0: r0};
        @(posedge clock);
        store_req.valid <= 1'b0;
        #1;
    endtask

    task rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = rdata;
    endtask

    task wait_done;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 200)
        begin
            @(posedge clock);
            #1 n++;
        end
        chk(n < 200, 1'b1);
        repeat (3) @(posedge clock);
        #1;
    endtask

    task tread(input logic [14:0] pc, input logic [14:0] a, input logic exp);
        fetch_pc <= pc;
        tr_addr <= a;
        tr_req <= 1'b1;
        @(posedge clock);
        tr_req <= 1'b0;
        #1 chk(tr_allow, exp);
    endtask

    // Clock and hang limit
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            final_report;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, vib, reg_write, reg_read, tr_req, cerase, slow} = 7'h00;
        {reg_addr, reg_wdata, fetch_pc, tr_addr} = 42'h0;
        store_req = '0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        #1 chk(lock, 8'hff);
        rd(SPAG_OFF_LOCK);
        chk(d, 8'hff);
        // Concurrent erase keeps running, busy reads one
        slow <= 1'b1;
        store(8'h03, 15'h3f00, 15'h0100, 8'h00);
        chk({fcmd.valid, fcmd.cmd, fcmd.target}, {1'b1, SPAG_CMD_ERASE, 15'h0100});
        chk({busy, stall}, 2'b10);
        rd(SPAG_OFF_CTRL);
        chk(d[SPAG_BIT_BUSY], 1'b1);
        wait_done;
        store(8'h11, 15'h3f00, 15'h0000, 8'h00);
        repeat (2) @(posedge clock);
        #1 chk(busy, 1'b0);
        // Stall region write halts until done
        slow <= 1'b0;
        store(8'h05, 15'h3f00, 15'h3900, 8'h00);
        chk({fcmd.valid, fcmd.cmd, stall, busy}, {1'b1, SPAG_CMD_WRITE, 2'b10});
        rd(SPAG_OFF_STAT);
        chk(d[2:0], 3'b011);
        wait_done;
        chk(stall, 1'b0);
        // Store from the app section does nothing
        store(8'h03, 15'h0010, 15'h0100, 8'h00);
        chk({fcmd.valid, busy, stall}, 3'b000);
        // Lock set from r0, both fields no read or write
        store(8'h09, 15'h3f00, 15'h0000, 8'hc3);
        wait_done;
        chk(lock, 8'hc3);
        store(8'h03, 15'h3f00, 15'h0100, 8'h00);
        chk({fcmd.valid, busy}, 2'b00);
        store(8'h05, 15'h3f00, 15'h3f40, 8'h00);
        chk({fcmd.valid, stall}, 2'b00);
        tread(15'h3f00, 15'h0100, 1'b0);
        tread(15'h0010, 15'h3f10, 1'b0);
        // Interrupt suppression both ways
        vib <= 1'b1;
        fetch_pc <= 15'h0010;
        repeat (3) @(posedge clock);
        #1 chk(irq, 1'b1);
        vib <= 1'b0;
        fetch_pc <= 15'h3f00;
        repeat (3) @(posedge clock);
        #1 chk(irq, 1'b1);
        // Chip erase restores locks, reads allowed again
        cerase <= 1'b1;
        @(posedge clock);
        cerase <= 1'b0;
        @(posedge clock);
        #1 chk(lock, 8'hff);
        tread(15'h3f00, 15'h0100, 1'b1);
        final_report;
    end
endmodule
